/* File: design/lcs_top.v */
// Limit comparator with classification statistics
`timescale 1ns/1ps
`include "lcs_defs.vh"
// Function
// RULE1: Value below active lower limit increments the below counter.
// RULE2: Value within active limits inclusive increments the in-range counter.
// RULE3: Value strictly above active upper limit increments the above counter.
// RULE4: Total counter increments once for every recorded measurement.
// RULE5: Statistics query returns above, in, below, total in that order.
// RULE6: Counters hold still during continuous measurement mode.
// RULE7: Measurements ending in error change no counter.
// RULE8: Statistics clear command zeroes all four counters.
// RULE9: Written upper limit stays pending until a valid commit.
// RULE10: Upper limit must exceed lower limit, else commit is invalid.
// RULE11: Written lower limit takes effect only after commit.
// RULE12: Limit without unit is taken in the base ohm unit.
// RULE13: Eleven unit suffixes are accepted and converted.
// RULE14: Host re-enters nominal and limits after a display unit change.
// RULE15: Limit query returns the selected pending limit with its unit.
// RULE16: After reset the upper limit is 110 ohm.
// RULE17: Invalid commit logs error -220 and sets execution error bit 4.
// RULE18: Each limit must differ from nominal by under 100 percent.
// RULE19: Shadow limits copy atomically to active ones on successful commit.
module lcs_top #(
	parameter VAL_W = `LCS_VAL_W,
	parameter CNT_W = `LCS_CNT_W
) (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST,
	// Limit writes: value mantissa, unit code, strobes
	input wire [VAL_W-1:0] WR_VALUE,
	input wire [3:0] WR_UNIT,
	input wire WR_UNIT_GIVEN,
	input wire UPPER_LIMIT_CMD,
	input wire LOWER_LIMIT_CMD,
	input wire NOMINAL_VALUE_CMD,
	input wire LIMIT_COMMIT_CMD,
	// Queries and statistics clear
	input wire LIMIT_QUERY,
	input wire LIMIT_QUERY_SEL_UPPER,
	input wire STATS_QUERY,
	input wire STATS_CLEAR_CMD,
	// Measurement results
	input wire MEAS_DONE,
	input wire MEAS_ERROR,
	input wire MEAS_CONTINUOUS,
	input wire [VAL_W-1:0] MEAS_VALUE,
	// Query answers
	output reg LIMIT_RESP_VALID,
	output reg [VAL_W-1:0] LIMIT_RESP_VALUE,
	output reg [3:0] LIMIT_RESP_UNIT,
	output reg STATS_RESP_VALID,
	output reg [CNT_W-1:0] STATS_ABOVE,
	output reg [CNT_W-1:0] STATS_IN,
	output reg [CNT_W-1:0] STATS_BELOW,
	output reg [CNT_W-1:0] STATS_TOTAL,
	// Active limits and error report
	output reg [VAL_W-1:0] ACTIVE_LOWER,
	output reg [VAL_W-1:0] ACTIVE_UPPER,
	output reg COMMIT_OK,
	output reg ERR_PULSE,
	output reg [15:0] ERR_CODE,
	output reg ESR_EXEC_ERR
);

	// ----------------------------------------
	// Unit conversion to milliohm base steps
	// ----------------------------------------
	function [VAL_W-1:0] to_base;
		input [VAL_W-1:0] v;
		input [3:0] u;
		input given;
		reg [63:0] p;
		begin
			p = {{(64-VAL_W){1'b0}}, v};
			if (!given) begin
				p = p * `LCS_SC_KILO; // RULE12
			end else begin
				case (u) // RULE13
					`LCS_U_OHM: p = p * `LCS_SC_KILO;
					`LCS_U_UOHM: p = p / `LCS_SC_KILO;
					`LCS_U_MOHM: p = p;
					`LCS_U_KOHM: p = p * `LCS_SC_MEGA;
					`LCS_U_MAOHM: p = p * `LCS_SC_GIGA;
					`LCS_U_PM: p = p * `LCS_SC_KILO;
					`LCS_U_PKM: p = p;
					`LCS_U_P10FT: p = p * `LCS_SC_HECTO;
					`LCS_U_PKFT: p = p;
					`LCS_U_COND: p = p * `LCS_SC_KILO;
					`LCS_U_RES: p = p * `LCS_SC_KILO;
					default: p = p * `LCS_SC_KILO;
				endcase
			end
			to_base = p[VAL_W-1:0];
		end
	endfunction

	// ----------------------------------------
	// Shadow and active limits
	// ----------------------------------------
	reg [VAL_W-1:0] sh_low_q;
	reg [VAL_W-1:0] sh_upp_q;
	reg [VAL_W-1:0] sh_nom_q;
	reg [3:0] low_unit_q;
	reg [3:0] upp_unit_q;
	wire [VAL_W-1:0] conv = to_base(WR_VALUE, WR_UNIT, WR_UNIT_GIVEN);
	wire [3:0] unit_eff = WR_UNIT_GIVEN ? WR_UNIT : `LCS_U_OHM;
	wire ordered = sh_upp_q > sh_low_q; // RULE10
	// Each limit within 100 percent of nominal: 0 < limit < 2*nominal
	wire [VAL_W:0] nom2 = {sh_nom_q, 1'b0};
	wire low_near = (sh_low_q != {VAL_W{1'b0}}) && ({1'b0, sh_low_q} < nom2); // RULE18
	wire upp_near = (sh_upp_q != {VAL_W{1'b0}}) && ({1'b0, sh_upp_q} < nom2); // RULE18
	wire nom_ok = sh_nom_q != {VAL_W{1'b0}};
	wire valid = ordered && low_near && upp_near && nom_ok;

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			sh_low_q <= `LCS_RST_LOW;
			sh_upp_q <= `LCS_RST_UPP; // RULE16
			sh_nom_q <= `LCS_RST_NOM;
			low_unit_q <= `LCS_U_OHM;
			upp_unit_q <= `LCS_U_OHM;
			ACTIVE_LOWER <= `LCS_RST_LOW;
			ACTIVE_UPPER <= `LCS_RST_UPP; // RULE16
			COMMIT_OK <= 1'b0;
			ERR_PULSE <= 1'b0;
			ERR_CODE <= `LCS_ERR_NONE;
			ESR_EXEC_ERR <= 1'b0;
			LIMIT_RESP_VALID <= 1'b0;
			LIMIT_RESP_VALUE <= {VAL_W{1'b0}};
			LIMIT_RESP_UNIT <= `LCS_U_OHM;
		end else begin
			COMMIT_OK <= 1'b0;
			ERR_PULSE <= 1'b0;
			LIMIT_RESP_VALID <= 1'b0;
			if (UPPER_LIMIT_CMD) begin
				sh_upp_q <= conv; // RULE9
				upp_unit_q <= unit_eff;
			end
			if (LOWER_LIMIT_CMD) begin
				sh_low_q <= conv; // RULE11
				low_unit_q <= unit_eff;
			end
			if (NOMINAL_VALUE_CMD) begin
				sh_nom_q <= conv;
			end
			if (LIMIT_COMMIT_CMD) begin
				if (valid) begin
					ACTIVE_LOWER <= sh_low_q; // RULE19
					ACTIVE_UPPER <= sh_upp_q; // RULE9
					COMMIT_OK <= 1'b1;
				end else begin
					ERR_PULSE <= 1'b1; // RULE17
					ERR_CODE <= `LCS_ERR_PARAM;
					ESR_EXEC_ERR <= 1'b1;
				end
			end
			if (LIMIT_QUERY) begin
				LIMIT_RESP_VALID <= 1'b1; // RULE15
				LIMIT_RESP_VALUE <= LIMIT_QUERY_SEL_UPPER ? sh_upp_q : sh_low_q;
				LIMIT_RESP_UNIT <= LIMIT_QUERY_SEL_UPPER ? upp_unit_q : low_unit_q;
			end
		end
	end

	// ----------------------------------------
	// Classification counters
	// ----------------------------------------
	reg [CNT_W-1:0] above_q;
	reg [CNT_W-1:0] in_q;
	reg [CNT_W-1:0] below_q;
	reg [CNT_W-1:0] total_q;
	wire rec = MEAS_DONE && !MEAS_ERROR && !MEAS_CONTINUOUS; // RULE6 RULE7
	wire is_below = MEAS_VALUE < ACTIVE_LOWER;
	wire is_above = MEAS_VALUE > ACTIVE_UPPER;

	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			above_q <= {CNT_W{1'b0}};
			in_q <= {CNT_W{1'b0}};
			below_q <= {CNT_W{1'b0}};
			total_q <= {CNT_W{1'b0}};
		end else if (STATS_CLEAR_CMD) begin
			above_q <= {CNT_W{1'b0}}; // RULE8
			in_q <= {CNT_W{1'b0}};
			below_q <= {CNT_W{1'b0}};
			total_q <= {CNT_W{1'b0}};
		end else if (rec) begin
			total_q <= total_q + 1'b1; // RULE4
			if (is_below) begin
				below_q <= below_q + 1'b1; // RULE1
			end else if (is_above) begin
				above_q <= above_q + 1'b1; // RULE3
			end else begin
				in_q <= in_q + 1'b1; // RULE2
			end
		end
	end

	// ----------------------------------------
	// Statistics answer
	// ----------------------------------------
	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			STATS_RESP_VALID <= 1'b0;
			STATS_ABOVE <= {CNT_W{1'b0}};
			STATS_IN <= {CNT_W{1'b0}};
			STATS_BELOW <= {CNT_W{1'b0}};
			STATS_TOTAL <= {CNT_W{1'b0}};
		end else begin
			STATS_RESP_VALID <= STATS_QUERY;
			if (STATS_QUERY) begin
				STATS_ABOVE <= above_q; // RULE5
				STATS_IN <= in_q;
				STATS_BELOW <= below_q;
				STATS_TOTAL <= total_q;
			end
		end
	end

endmodule

/* File: design/lcs_defs.vh */
// Constants for the limit comparator statistics block
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH
// Value width and counter width defaults
`define LCS_VAL_W 32
`define LCS_CNT_W 16
// Reset limits in milliohm base steps: 100 ohm nominal, 90 ohm lower, 110 ohm upper
`define LCS_RST_NOM 32'h000186A0
`define LCS_RST_LOW 32'h00015F90
`define LCS_RST_UPP 32'h0001ADB0
// Unit codes
`define LCS_U_OHM 4'h0
`define LCS_U_UOHM 4'h1
`define LCS_U_MOHM 4'h2
`define LCS_U_KOHM 4'h3
`define LCS_U_MAOHM 4'h4
`define LCS_U_PM 4'h5
`define LCS_U_PKM 4'h6
`define LCS_U_P10FT 4'h7
`define LCS_U_PKFT 4'h8
`define LCS_U_COND 4'h9
`define LCS_U_RES 4'hA
// Error code of a failed commit
`define LCS_ERR_PARAM 16'hFF24
// Bit of the standard event status register for execution errors
`define LCS_ESR_EXE 4
// Scale factors to milliohm base steps
`define LCS_SC_KILO 64'h3E8
`define LCS_SC_MEGA 64'hF4240
`define LCS_SC_GIGA 64'h3B9ACA00
`define LCS_SC_HECTO 64'h64
// Error code while no error is logged
`define LCS_ERR_NONE 16'h0000
`endif

/* File: dv/lcs_props.sv */
// Assertion checker for the limit comparator statistics block
`timescale 1ns/1ps
module lcs_props #(parameter VAL_W = 32, parameter CNT_W = 16) (
	input logic CLK_SYS, RST, LIMIT_COMMIT_CMD, LIMIT_QUERY, STATS_QUERY,
	input logic STATS_CLEAR_CMD, MEAS_DONE, LIMIT_RESP_VALID, STATS_RESP_VALID,
	input logic COMMIT_OK, ERR_PULSE, ESR_EXEC_ERR,
	input logic [15:0] ERR_CODE,
	input logic [CNT_W-1:0] STATS_ABOVE, STATS_IN, STATS_BELOW, STATS_TOTAL,
	input logic [VAL_W-1:0] ACTIVE_LOWER, ACTIVE_UPPER
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (RST);
property p_sq; STATS_QUERY |=> STATS_RESP_VALID; endproperty
a_sq: assert property (p_sq) else $error("stats answer missing");
property p_lq; LIMIT_QUERY |=> LIMIT_RESP_VALID; endproperty
a_lq: assert property (p_lq) else $error("limit answer missing");
property p_cmt; LIMIT_COMMIT_CMD |=> COMMIT_OK != ERR_PULSE; endproperty
a_cmt: assert property (p_cmt) else $error("commit without outcome");
property p_er; ERR_PULSE |-> ERR_CODE == 16'hFF24 && ESR_EXEC_ERR; endproperty
a_er: assert property (p_er) else $error("bad error report");
property p_ok; COMMIT_OK |-> ACTIVE_UPPER > ACTIVE_LOWER; endproperty
a_ok: assert property (p_ok) else $error("unordered limits accepted");
property p_act; $changed(ACTIVE_LOWER) || $changed(ACTIVE_UPPER) |-> COMMIT_OK; endproperty
a_act: assert property (p_act) else $error("limits moved without commit");
property p_sum; STATS_RESP_VALID |-> STATS_TOTAL == STATS_ABOVE + STATS_IN + STATS_BELOW;
endproperty
a_sum: assert property (p_sum) else $error("total differs from sum");
property p_clr; STATS_CLEAR_CMD ##1 (STATS_QUERY && !MEAS_DONE) |=> STATS_TOTAL == 0;
endproperty
a_clr: assert property (p_clr) else $error("clear left counts");
cover property (COMMIT_OK);
cover property (ERR_PULSE);
cover property (STATS_RESP_VALID && STATS_TOTAL != 0);
endmodule
bind lcs_top lcs_props #(.VAL_W(VAL_W), .CNT_W(CNT_W)) u_lcs_props (.CLK_SYS(CLK_SYS), .RST(RST),
	.LIMIT_COMMIT_CMD(LIMIT_COMMIT_CMD), .LIMIT_QUERY(LIMIT_QUERY), .STATS_QUERY(STATS_QUERY),
	.STATS_CLEAR_CMD(STATS_CLEAR_CMD), .MEAS_DONE(MEAS_DONE), .LIMIT_RESP_VALID(LIMIT_RESP_VALID),
	.STATS_RESP_VALID(STATS_RESP_VALID), .COMMIT_OK(COMMIT_OK), .ERR_PULSE(ERR_PULSE),
	.ESR_EXEC_ERR(ESR_EXEC_ERR), .ERR_CODE(ERR_CODE), .STATS_ABOVE(STATS_ABOVE),
	.STATS_IN(STATS_IN), .STATS_BELOW(STATS_BELOW), .STATS_TOTAL(STATS_TOTAL),
	.ACTIVE_LOWER(ACTIVE_LOWER), .ACTIVE_UPPER(ACTIVE_UPPER));

/* File: dv/lcs_host.sv */
// Host model that writes limits and commits them
`timescale 1ns/1ps
module lcs_host (input logic clk, output logic [31:0] v, output logic [3:0] u,
	output logic g, output logic [3:0] s);
initial {v, u, g, s} = 0;
task automatic put(input int k, input logic [31:0] x);
	@(negedge clk) v = x;
	s = 4'h1 << k;
	@(negedge clk) s = 0;
	v = ~x;
endtask
task automatic cfg(input int l, h, n, input logic [3:0] un, input logic gv);
	u = un;
	g = gv;
	put(0, l);
	put(1, h);
	put(2, n);
	put(3, 0);
endtask
endmodule

/* File: dv/test_lcs_top.sv */
// Self-checking testbench of the limit comparator statistics block
`timescale 1ns/1ps
module test_lcs_top;
logic clk_sys = 0, rst = 1, lq = 0, sel = 0, sq = 0, clr = 0, md = 0, me = 0, mc = 0;
logic [31:0] mv = 0, v, al, au, lrval;
logic [3:0] u, s, lru, pu = 0;
logic g, lrv, srv, ok, ep, esr;
logic [15:0] a, b, c, t, ec;
int miscompares = 0, num_checks = 0, lo = 90000, hi = 110000, na, ni, nb, nt, pl = 90000, ph = 110000;
lcs_host u_lcs_host (.clk(clk_sys), .v(v), .u(u), .g(g), .s(s));
lcs_top u_lcs_top (.CLK_SYS(clk_sys), .RST(rst), .WR_VALUE(v), .WR_UNIT(u), .WR_UNIT_GIVEN(g),
	.LOWER_LIMIT_CMD(s[0]), .UPPER_LIMIT_CMD(s[1]), .NOMINAL_VALUE_CMD(s[2]),
	.LIMIT_COMMIT_CMD(s[3]), .LIMIT_QUERY(lq), .LIMIT_QUERY_SEL_UPPER(sel), .STATS_QUERY(sq),
	.STATS_CLEAR_CMD(clr), .MEAS_DONE(md), .MEAS_ERROR(me), .MEAS_CONTINUOUS(mc),
	.MEAS_VALUE(mv), .LIMIT_RESP_VALID(lrv), .LIMIT_RESP_VALUE(lrval), .LIMIT_RESP_UNIT(lru),
	.STATS_RESP_VALID(srv), .STATS_ABOVE(a), .STATS_IN(b), .STATS_BELOW(c), .STATS_TOTAL(t),
	.ACTIVE_LOWER(al), .ACTIVE_UPPER(au), .COMMIT_OK(ok), .ERR_PULSE(ep), .ERR_CODE(ec),
	.ESR_EXEC_ERR(esr));
initial forever #50 clk_sys = ~clk_sys;
task chk(input logic k);
	num_checks++;
	if (!k) begin
		miscompares++;
		$display("FAIL %0t mismatch", $time);
	end
endtask
task stop_test;
	if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
function automatic int base(input int x, input logic [3:0] un, input logic gv);
	return (gv && un == 4'h2) ? x : x * 1000;
endfunction
task meas(input int n);
	repeat (n) begin
		@(negedge clk_sys) md = 1;
		mv = $urandom % 4 ? $urandom % 220000 : ($urandom % 2 ? hi + $urandom % 2 : lo - 1);
		me = $urandom % 4 == 0;
		mc = $urandom % 4 == 0;
		if (!me && !mc) begin
			nt++;
			if (mv < lo) nb++;
			else if (mv > hi) na++;
			else ni++;
		end
	end
	@(negedge clk_sys) md = 0;
endtask
task stats(input logic cl);
	@(negedge clk_sys) clr = cl;
	@(negedge clk_sys) clr = 0;
	if (cl) {na, ni, nb, nt} = 0;
	sq = 1;
	lq = 1;
	sel = $urandom;
	@(negedge clk_sys) sq = 0;
	lq = 0;
	chk(srv === 1'b1 && a === na[15:0] && b === ni[15:0] && c === nb[15:0] && t === nt[15:0]);
	chk(lrv === 1'b1 && lrval === (sel ? ph[31:0] : pl[31:0]) && lru === pu);
endtask
task commit(input int l, h, n, input logic [3:0] un, input logic gv, input int ml, mh);
	u_lcs_host.cfg(l, h, n, un, gv);
	pl = base(l, un, gv);
	ph = base(h, un, gv);
	pu = gv ? un : 4'h0;
	if (ml != 0) begin
		lo = ml;
		hi = mh;
	end
	chk(ok === (ml != 0) && al === lo[31:0] && au === hi[31:0]);
	if (ml == 0) chk(ep === 1'b1 && ec === 16'hFF24 && esr === 1'b1);
endtask
initial begin
	void'($urandom(63803));
	{na, ni, nb, nt} = 0;
	repeat (16) @(posedge clk_sys);
	@(negedge clk_sys) rst = 0;
	chk(au === 32'h0001ADB0);
	meas(40);
	stats(0);
	u_lcs_host.put(0, 95);
	pl = 95000;
	chk(al === 32'h00015F90);
	commit(95, 105, 100, 4'h0, 1'b0, 95000, 105000);
	meas(40);
	stats(0);
	commit(120, 100, 110, 4'h0, 1'b0, 0, 0);
	commit(50, 210, 100, 4'h0, 1'b0, 0, 0);
	commit(92000, 108000, 100000, 4'h2, 1'b1, 92000, 108000);
	meas(40);
	stats(0);
	stats(1);
	@(negedge clk_sys) rst = 1;
	@(negedge clk_sys) rst = 0;
	chk(al === 32'h00015F90 && au === 32'h0001ADB0 && esr === 1'b0);
	lo = 90000;
	hi = 110000;
	pl = lo;
	ph = hi;
	pu = 4'h0;
	meas(20);
	stats(0);
	stop_test;
end
initial begin
	#1000000;
	miscompares++;
	stop_test;
end
endmodule
